// ===== rtl/sensor_bus_timing_guard.sv
// Purpose: scl timeout bus reset, ibi issue and arbitration, i2c spike filter
// Assumes: scl and sda pins are asynchronous to sys_clk
// Notes: sda is open drain, sda_out is always low and sda_oe pulls it
`timescale 1ns/100ps
`default_nettype none
`include "guard_defines.svh"

module sensor_bus_timing_guard
   import guard_pkg::*;
#(
   parameter int TIMEOUT_CYC = `TIMEOUT_CYC,
   parameter int AVAL_CYC = `AVAL_CYC
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // bus pins
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // configuration from command decoder
   input wire logic cfg_load,
   input wire cfg_t cfg_in,
   output cfg_t cfg,
   // error status
   input wire logic parity_err_set,
   input wire logic pec_err_set,
   input wire logic status_clear,
   output status_t status,
   // in-band interrupt
   input wire logic [6:0] dev_addr,
   input wire logic ibi_enable,
   input wire logic ibi_event,
   output logic ibi_pending,
   output logic ibi_busy,
   output logic ibi_won,
   output logic ibi_lost,
   // bus state
   output logic bus_idle,
   output logic bus_reset
);

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic scl_s1_r;
   logic scl_s2_r;
   logic sda_s1_r;
   logic sda_s2_r;

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         scl_s1_r <= 1'b1;
         scl_s2_r <= 1'b1;
         sda_s1_r <= 1'b1;
         sda_s2_r <= 1'b1;
      end else begin
         scl_s1_r <= scl_in;
         scl_s2_r <= scl_s1_r;
         sda_s1_r <= sda_in;
         sda_s2_r <= sda_s1_r;
      end
   end

   // ----------------------------------------------------------------
   // spike filters, only in i2c mode
   // ----------------------------------------------------------------
   logic cfg_i3c;
   logic scl_f;
   logic sda_f;

   assign cfg_i3c = cfg.interface_select;

   // filtering in i3c would eat legal 35 ns high phases
   spike_filter #(.CYC(`LPF_CYC)) u_scl_filt (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .enable(!cfg_i3c),
      .din(scl_s2_r),
      .dout(scl_f)
   );

   spike_filter #(.CYC(`LPF_CYC)) u_sda_filt (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .enable(!cfg_i3c),
      .din(sda_s2_r),
      .dout(sda_f)
   );

   // ----------------------------------------------------------------
   // edge detection, idle and timeout counters
   // ----------------------------------------------------------------
   logic scl_d_r;
   logic sda_d_r;
   logic scl_fall;
   logic scl_rise;
   logic any_edge;
   logic start_det;
   logic [`AVAL_W-1:0] idle_cnt_r;
   logic [`AVAL_W-1:0] idle_cnt_nxt;
   logic [`TIMEOUT_W-1:0] to_cnt_r;
   logic [`TIMEOUT_W-1:0] to_cnt_nxt;
   logic rst_pulse_r;
   logic rst_pulse_nxt;

   assign scl_fall = scl_d_r && !scl_f;
   assign scl_rise = !scl_d_r && scl_f;
   assign any_edge = (scl_d_r != scl_f) || (sda_d_r != sda_f);
   assign start_det = sda_d_r && !sda_f && scl_f;

   always_comb begin
      idle_cnt_nxt = idle_cnt_r;
      if (any_edge) begin
         idle_cnt_nxt = '0;
      end else if (idle_cnt_r != AVAL_CYC[`AVAL_W-1:0]) begin
         idle_cnt_nxt = idle_cnt_r + 1'b1;
      end
      to_cnt_nxt = '0;
      rst_pulse_nxt = 1'b0;
      // counts raw synchronised scl so the filter cannot mask a stuck line
      if (!scl_s2_r) begin
         if (to_cnt_r == TIMEOUT_CYC[`TIMEOUT_W-1:0]) begin
            to_cnt_nxt = to_cnt_r;
         end else begin
            to_cnt_nxt = to_cnt_r + 1'b1;
         end
         // fires once per low period
         rst_pulse_nxt = (to_cnt_r == TIMEOUT_CYC[`TIMEOUT_W-1:0] - 1'b1);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
         idle_cnt_r <= '0;
         to_cnt_r <= '0;
         rst_pulse_r <= 1'b0;
      end else begin
         scl_d_r <= scl_f;
         sda_d_r <= sda_f;
         idle_cnt_r <= idle_cnt_nxt;
         to_cnt_r <= to_cnt_nxt;
         rst_pulse_r <= rst_pulse_nxt;
      end
   end

   assign bus_idle = (idle_cnt_r == AVAL_CYC[`AVAL_W-1:0]);
   assign bus_reset = rst_pulse_r;

   // ----------------------------------------------------------------
   // configuration and status
   // ----------------------------------------------------------------
   cfg_t cfg_r;
   cfg_t cfg_nxt;
   status_t stat_r;
   status_t stat_nxt;

   always_comb begin
      cfg_nxt = cfg_r;
      stat_nxt = stat_r;
      if (cfg_load) begin
         cfg_nxt = cfg_in;
      end
      if (status_clear) begin
         stat_nxt = '0;
      end
      if (rst_pulse_r) begin
         cfg_nxt = '0;
         cfg_nxt.host_id_field = `HOST_ID_RST;
         stat_nxt = '0;
      end
      // a new error beats a software clear in the same cycle
      if (parity_err_set) begin
         stat_nxt.parity_fail_flag = 1'b1;
      end
      if (pec_err_set) begin
         stat_nxt.pec_fail_flag = 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         cfg_r <= '{host_id_field: `HOST_ID_RST, default: 1'b0};
         stat_r <= '0;
      end else begin
         cfg_r <= cfg_nxt;
         stat_r <= stat_nxt;
      end
   end

   assign cfg = cfg_r;
   assign status = stat_r;

   // ----------------------------------------------------------------
   // in-band interrupt issue and address arbitration
   // ----------------------------------------------------------------
   ibi_state_t st_r;
   ibi_state_t st_nxt;
   logic pend_r;
   logic pend_nxt;
   logic oe_r;
   logic oe_nxt;
   logic [3:0] bit_r;
   logic [3:0] bit_nxt;
   logic won_r;
   logic won_nxt;
   logic lost_r;
   logic lost_nxt;
   logic armed;

   // address msb first, then read bit
   function automatic logic frame_bit(input logic [6:0] addr, input logic [3:0] idx);
      logic [7:0] frame;
      frame = {addr, 1'b1};
      frame_bit = frame[3'(`ADDR_BITS - 1 - idx)];
   endfunction

   assign armed = pend_r && cfg_i3c && ibi_enable;

   always_comb begin
      st_nxt = st_r;
      pend_nxt = pend_r || (ibi_event && cfg_i3c);
      oe_nxt = oe_r;
      bit_nxt = bit_r;
      won_nxt = 1'b0;
      lost_nxt = 1'b0;
      unique case (st_r)
         IBI_IDLE: begin
            oe_nxt = 1'b0;
            // host start also lets us join its address phase
            if (armed && (bus_idle || start_det)) begin
               st_nxt = IBI_HOLD;
               oe_nxt = 1'b1;
            end
         end
         IBI_HOLD: begin
            if (scl_fall) begin
               st_nxt = IBI_SHIFT;
               bit_nxt = '0;
               oe_nxt = !frame_bit(dev_addr, 4'h0);
            end
         end
         IBI_SHIFT: begin
            if (scl_rise && !oe_r && !sda_f) begin
               // released a one but line low: host wins, retry later
               st_nxt = IBI_IDLE;
               oe_nxt = 1'b0;
               lost_nxt = 1'b1;
            end else if (scl_rise && bit_r == 4'(`ADDR_BITS - 1)) begin
               st_nxt = IBI_IDLE;
               pend_nxt = 1'b0;
               won_nxt = 1'b1;
            end else if (scl_fall) begin
               bit_nxt = bit_r + 1'b1;
               oe_nxt = !frame_bit(dev_addr, bit_r + 1'b1);
            end
         end
      endcase
      if (rst_pulse_r) begin
         st_nxt = IBI_IDLE;
         pend_nxt = 1'b0;
         oe_nxt = 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         st_r <= IBI_IDLE;
         pend_r <= 1'b0;
         oe_r <= 1'b0;
         bit_r <= '0;
         won_r <= 1'b0;
         lost_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         pend_r <= pend_nxt;
         oe_r <= oe_nxt;
         bit_r <= bit_nxt;
         won_r <= won_nxt;
         lost_r <= lost_nxt;
      end
   end

   assign sda_out = 1'b0;
   assign sda_oe = oe_r;
   assign ibi_pending = pend_r;
   assign ibi_busy = (st_r != IBI_IDLE);
   assign ibi_won = won_r;
   assign ibi_lost = lost_r;

endmodule
`default_nettype wire

// ===== rtl/guard_defines.svh
// Purpose: timing counts, reset values and field sizes for the bus timing guard
// Assumes: sys_clk at 40 MHz (25 ns period)
// Notes: times kept in their own unit, cycle counts derived from them
`ifndef GUARD_DEFINES_SVH
`define GUARD_DEFINES_SVH

// ----------------------------------------------------------------
// clock
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 25
`define CLK_MHZ 40

// ----------------------------------------------------------------
// scl low timeout window, microseconds
// ----------------------------------------------------------------
`define T_TIMEOUT_MIN_US 10000
`define T_TIMEOUT_MAX_US 50000
// terminal count sits mid-window so +/-50 % oscillator error stays inside
`define TIMEOUT_CYC (((`T_TIMEOUT_MIN_US + `T_TIMEOUT_MAX_US) / 2) * `CLK_MHZ)
`define TIMEOUT_W 22

// ----------------------------------------------------------------
// bus available time, ns (least time, round up)
// ----------------------------------------------------------------
`define T_AVAL_NS 1000
`define AVAL_CYC ((`T_AVAL_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define AVAL_W 8

// ----------------------------------------------------------------
// spike filter, ns (longest spike, round down, at least one cycle)
// ----------------------------------------------------------------
`define T_LPF_NS 50
`define LPF_CYC (((`T_LPF_NS / `CLK_PERIOD_NS) < 1) ? 1 : (`T_LPF_NS / `CLK_PERIOD_NS))
`define LPF_W 4

// ----------------------------------------------------------------
// reset values and address frame length
// ----------------------------------------------------------------
`define HOST_ID_RST 3'h7
`define ADDR_BITS 8

`endif

// ===== rtl/guard_pkg.sv
// Purpose: types shared by the bus timing guard
// Assumes: nothing
// Notes: configuration and status travel as packed structs
package guard_pkg;

   typedef struct packed {
      logic [2:0] host_id_field;
      logic interface_select;
      logic pec_enable;
      logic parity_check_disable;
      logic error_interrupt_enable;
   } cfg_t;

   typedef struct packed {
      logic parity_fail_flag;
      logic pec_fail_flag;
   } status_t;

   typedef enum logic [1:0] {IBI_IDLE, IBI_HOLD, IBI_SHIFT} ibi_state_t;

endpackage

// ===== rtl/spike_filter.sv
// Purpose: suppress short pulses on one synchronised bus line
// Assumes: input already synchronised to sys_clk
// Notes: bypassed when enable is low
`timescale 1ns/100ps
`default_nettype none
`include "guard_defines.svh"
module spike_filter #(
   parameter int CYC = `LPF_CYC
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // control
   input wire logic enable,
   // line
   input wire logic din,
   output logic dout
);

   logic out_r;
   logic out_nxt;
   logic [`LPF_W-1:0] cnt_r;
   logic [`LPF_W-1:0] cnt_nxt;

   // ----------------------------------------------------------------
   // a change must persist CYC+1 cycles before it passes
   // ----------------------------------------------------------------
   always_comb begin
      out_nxt = out_r;
      cnt_nxt = '0;
      if (!enable) begin
         out_nxt = din;
      end else if (din != out_r) begin
         if (cnt_r == CYC[`LPF_W-1:0]) begin
            out_nxt = din;
         end else begin
            cnt_nxt = cnt_r + 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         out_r <= 1'b1;
         cnt_r <= '0;
      end else begin
         out_r <= out_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   assign dout = out_r;

endmodule
`default_nettype wire

// ===== test/guard_sva.sv
// Purpose: port assertions for the bus timing guard
// Assumes: bound with the design's timeout count
// Notes: checks only, no output
`timescale 1ns/100ps
`default_nettype none
module guard_sva
   import guard_pkg::*;
#(
   parameter int TIMEOUT_CYC = 200
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // watched ports
   input wire logic scl_in,
   input wire logic parity_err_set,
   input wire logic pec_err_set,
   input wire logic ibi_enable,
   input wire cfg_t cfg,
   input wire status_t status,
   input wire logic sda_oe,
   input wire logic ibi_pending,
   input wire logic ibi_busy,
   input wire logic ibi_won,
   input wire logic bus_idle,
   input wire logic bus_reset
);
   int low_cnt;
   logic fired_r;
   // raw scl runs two cycles ahead of the synced copy
   always_ff @(posedge sys_clk) begin
      if (!rst_n || scl_in) begin
         low_cnt <= 0;
         fired_r <= 1'b0;
      end else begin
         low_cnt <= low_cnt + 1;
         fired_r <= fired_r || bus_reset;
      end
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   sequence s_armed;
      ibi_pending && cfg.interface_select && ibi_enable && bus_idle && !ibi_busy;
   endsequence
   sequence s_pull;
      ##[1:600] sda_oe;
   endsequence
   property p_issue;
      s_armed |-> s_pull;
   endproperty
   property p_oe_i3c;
      $rose(sda_oe) |-> $past(cfg.interface_select) && $past(ibi_pending);
   endproperty
   property p_idle;
      $rose(ibi_busy) |-> $past(bus_idle) || $past(bus_idle, 2);
   endproperty
   property p_won;
      ibi_won |-> !ibi_pending ##1 !ibi_won;
   endproperty
   property p_rst_cfg;
      bus_reset |=> cfg == 7'h70 && !sda_oe && !ibi_pending && !bus_reset;
   endproperty
   property p_rst_st;
      bus_reset && !parity_err_set && !pec_err_set |=> status == 2'h0;
   endproperty
   property p_to_min;
      bus_reset |-> low_cnt >= TIMEOUT_CYC;
   endproperty
   property p_to_max;
      low_cnt == TIMEOUT_CYC + 5 |-> fired_r;
   endproperty
   a_issue: assert property (p_issue) else $error("ibi late");
   a_oe_i3c: assert property (p_oe_i3c) else $error("sda pulled outside i3c");
   a_idle: assert property (p_idle) else $error("ibi on busy bus");
   a_won: assert property (p_won) else $error("won pulse wrong");
   a_rst_cfg: assert property (p_rst_cfg) else $error("bus reset state wrong");
   a_rst_st: assert property (p_rst_st) else $error("status kept");
   a_to_min: assert property (p_to_min) else $error("timeout early");
   a_to_max: assert property (p_to_max) else $error("timeout late");
endmodule
bind sensor_bus_timing_guard guard_sva #(.TIMEOUT_CYC(TIMEOUT_CYC)) guard_sva_inst (
   .sys_clk, .rst_n, .scl_in, .parity_err_set, .pec_err_set, .ibi_enable, .cfg, .status,
   .sda_oe, .ibi_pending, .ibi_busy, .ibi_won, .bus_idle, .bus_reset);
`default_nettype wire

// ===== test/bus_host_model.sv
// Purpose: host controller model driving scl
// Assumes: bench resolves the open drain sda
// Notes: scl stands high between frames
`timescale 1ns/100ps
`default_nettype none
module bus_host_model (
   // bus
   output logic scl,
   output logic sda_low,
   input wire logic sda
);
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   task automatic scl_set(input logic v);
      scl = v;
   endtask
   // command spacing the host keeps, bus left alone meanwhile
   task automatic hold_off(input int ns);
      #(ns);
   endtask
   // 200 ns bits, sampled just before the rise
   task automatic ibi_cycle(input logic [7:0] mine, output logic [7:0] got);
      for (int i = 0; i < 800 && sda; i++) #25;
      for (int i = 7; i >= 0; i--) begin
         scl = 1'b0;
         sda_low = !mine[i];
         #150;
         got[i] = sda;
         scl = 1'b1;
         #50;
      end
      sda_low = 1'b0;
   endtask
endmodule
`default_nettype wire

// ===== test/sensor_bus_timing_guard_tb.sv
// Purpose: self-checking bench for the bus timing guard
// Assumes: timeout cut to 200 cycles
// Notes: sda open drain, pulled up
`timescale 1ns/100ps
`default_nettype none
module sensor_bus_timing_guard_tb;
   import guard_pkg::*;
   logic sys_clk, rst_n, cfg_load, parity_err_set, pec_err_set, ibi_enable, ibi_event;
   logic spike, won_seen, lost_seen, rst_seen, sda_out, sda_oe, ibi_pending, ibi_busy;
   logic ibi_won, ibi_lost, bus_idle, bus_reset, status_clear;
   logic [7:0] got;
   cfg_t cfg_in, cfg;
   status_t status;
   wire logic scl, host_low, sda;
   int errors, total_checks, n;
   assign sda = !((sda_oe && !sda_out) || host_low || spike);
   sensor_bus_timing_guard #(.TIMEOUT_CYC(200)) sensor_bus_timing_guard_inst (
      .sys_clk, .rst_n, .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe, .cfg_load, .cfg_in,
      .cfg, .parity_err_set, .pec_err_set, .status_clear, .status, .dev_addr(7'h5A),
      .ibi_enable, .ibi_event, .ibi_pending, .ibi_busy, .ibi_won, .ibi_lost, .bus_idle,
      .bus_reset);
   bus_host_model bus_host_model_inst (.scl, .sda_low(host_low), .sda);
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = !sys_clk;
   end
   // pulses are one cycle, so keep sticky copies
   // held clear in reset so unknown outputs before the first edge do not stick
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         won_seen <= 1'b0;
         lost_seen <= 1'b0;
         rst_seen <= 1'b0;
      end else begin
         won_seen <= won_seen || ibi_won;
         lost_seen <= lost_seen || ibi_lost;
         rst_seen <= rst_seen || bus_reset;
      end
   end
   task automatic chk(input string s, input logic [7:0] e, input logic [7:0] v);
      total_checks++;
      if (v !== e) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", s, e, v);
      end
   endtask
   task automatic chk1(input string s, input logic e, input logic v);
      chk(s, {7'h00, e}, {7'h00, v});
   endtask
   task automatic cyc(input int k);
      repeat (k) @(negedge sys_clk);
   endtask
   task automatic fire;
      won_seen = 1'b0;
      lost_seen = 1'b0;
      ibi_event = 1'b1;
      cyc(1);
      ibi_event = 1'b0;
      for (n = 0; n < 600 && !sda_oe; n++) cyc(1);
   endtask
   // ----------
   // scenarios
   // ----------
   task automatic t_i2c_ibi;
      chk("cfg", 8'h70, {1'b0, cfg});
      ibi_enable = 1'b1;
      fire;
      chk1("pending", 1'b0, ibi_pending);
      chk1("sda_oe", 1'b0, sda_oe);
   endtask
   task automatic t_spike(input logic i3c, input logic e);
      cfg_in = {3'h2, i3c, 3'h7};
      cfg_load = 1'b1;
      cyc(1);
      cfg_load = 1'b0;
      for (n = 0; n < 100 && !bus_idle; n++) cyc(1);
      chk1("idle", 1'b1, bus_idle);
      spike = 1'b1;
      cyc(2);
      spike = 1'b0;
      cyc(8);
      chk1("idle after spike", e, bus_idle);
   endtask
   task automatic t_ibi(input logic [7:0] host, input logic win);
      fire;
      chk1("issued", 1'b1, n < 600);
      bus_host_model_inst.ibi_cycle(host, got);
      cyc(4);
      if (win) chk("address", 8'hB5, got);
      chk1("won", win, won_seen);
      chk1("lost", !win, lost_seen);
      chk1("pending", !win, ibi_pending);
   endtask
   task automatic t_timeout;
      cyc(50);
      chk1("retry", 1'b1, sda_oe);
      parity_err_set = 1'b1;
      pec_err_set = 1'b1;
      cyc(1);
      parity_err_set = 1'b0;
      pec_err_set = 1'b0;
      chk("status", 8'h03, {6'h00, status});
      bus_host_model_inst.scl_set(1'b0);
      cyc(150);
      chk1("early reset", 1'b0, rst_seen);
      cyc(70);
      chk1("bus_reset", 1'b1, rst_seen);
      chk("cfg", 8'h70, {1'b0, cfg});
      chk("status", 8'h00, {6'h00, status});
      chk1("pending", 1'b0, ibi_pending);
      chk1("sda_oe", 1'b0, sda_oe);
      bus_host_model_inst.scl_set(1'b1);
   endtask
   task automatic t_clear;
      parity_err_set = 1'b1;
      status_clear = 1'b1;
      cyc(1);
      parity_err_set = 1'b0;
      chk("set over clear", 8'h02, {6'h00, status});
      cyc(1);
      status_clear = 1'b0;
      chk("clear", 8'h00, {6'h00, status});
      bus_host_model_inst.hold_off(4000);
      bus_host_model_inst.hold_off(15000);
      bus_host_model_inst.hold_off(3000);
      bus_host_model_inst.hold_off(8000);
      bus_host_model_inst.hold_off(2500);
      bus_host_model_inst.hold_off(2500);
      bus_host_model_inst.hold_off(2500);
      chk("status after gaps", 8'h00, {6'h00, status});
      chk1("idle after gaps", 1'b1, bus_idle);
   endtask
   task automatic wrap_up;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      {rst_n, cfg_load, parity_err_set, pec_err_set, ibi_enable, ibi_event} = 6'h00;
      {spike, won_seen, lost_seen, rst_seen} = 4'h0;
      status_clear = 1'b0;
      cfg_in = 7'h00;
      errors = 0;
      total_checks = 0;
      cyc(12);
      rst_n = 1'b1;
      cyc(1);
      t_i2c_ibi;
      t_spike(1'b0, 1'b1);
      t_spike(1'b1, 1'b0);
      t_ibi(8'hFF, 1'b1);
      t_ibi(8'h00, 1'b0);
      t_timeout;
      t_clear;
      wrap_up;
   end
endmodule
`default_nettype wire
